// File: ccw_pkg.sv
// package: constants and types for the call / clear / watchdog-clear executor
package ccw_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PC_W = 10;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BIT_W = 3;
  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [9:0] PC_RST = 10'h000;
  localparam logic [9:0] PC_STEP = 10'h001;
  localparam logic [1:0] CALL_CYCLES = 2'h2;
  // ----------------------------------------------------------------
  // operation codes presented on i_op
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_CALL = 3'b001,
    OP_MEMORY_BYTE_ZERO = 3'b010,
    OP_MEMORY_BIT_ZERO = 3'b011,
    OP_WATCHDOG_CLEAR = 3'b100,
    OP_WATCHDOG_PRECLEAR_FIRST = 3'b101,
    OP_WATCHDOG_PRECLEAR_SECOND = 3'b110,
    OP_OTHER = 3'b111
  } ccw_op_t;
  // last pre-clear seen; an effective pair resets it to none
  typedef enum logic [1:0] {
    PRE_NONE = 2'b00,
    PRE_FIRST = 2'b01,
    PRE_SECOND = 2'b10
  } ccw_pre_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CALL2 = 1'b1
  } ccw_state_t;
endpackage : ccw_pkg

// File: ccw_exec.sv
// module: execution unit for call, memory clears and watchdog clears
`timescale 1ns/1ps
`default_nettype none
module ccw_exec (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // instruction
  input wire logic i_op_valid,
  input wire logic [2:0] i_op,
  input wire logic [9:0] i_call_addr,
  input wire logic [7:0] i_mem_addr,
  input wire logic [2:0] i_bit_sel,
  // data memory read value of the addressed byte
  input wire logic [7:0] i_mem_rdata,
  // program counter and stack
  output logic [9:0] o_pc,
  output logic o_busy,
  output logic o_push,
  output logic [9:0] o_push_data,
  // data memory write
  output logic o_mem_we,
  output logic [7:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  // watchdog side
  output logic o_watchdog_counter_clr,
  output logic o_timeout_flag_clr,
  output logic o_power_down_flag_clr,
  output logic o_status_we
);
  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  logic rst_n;
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ccw_pkg::ccw_state_t st;
    ccw_pkg::ccw_pre_t pre;
    logic [9:0] pc;
    logic [9:0] target;
    logic busy;
    logic push;
    logic [9:0] push_data;
    logic mem_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic wdt_clr;
    logic status_we;
  } ccw_state_s_t;

  ccw_state_s_t s_ff;
  ccw_state_s_t nxt_s;
  ccw_pkg::ccw_op_t op;
  logic take;
  assign op = ccw_pkg::ccw_op_t'(i_op);
  // a new instruction is only taken outside the second call cycle
  assign take = i_op_valid && (s_ff.st == ccw_pkg::ST_IDLE);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.push = 1'b0;
    nxt_s.mem_we = 1'b0;
    nxt_s.wdt_clr = 1'b0;
    nxt_s.status_we = 1'b0;
    case (s_ff.st)
      ccw_pkg::ST_CALL2: begin
        // second cycle: load the target address
        nxt_s.pc = s_ff.target;
        nxt_s.busy = 1'b0;
        nxt_s.st = ccw_pkg::ST_IDLE;
      end
      ccw_pkg::ST_IDLE: begin
        if (take) begin
          nxt_s.pc = s_ff.pc + ccw_pkg::PC_STEP;
          case (op)
            ccw_pkg::OP_CALL: begin
              nxt_s.push = 1'b1;
              nxt_s.push_data = s_ff.pc + ccw_pkg::PC_STEP;
              nxt_s.target = i_call_addr;
              nxt_s.busy = 1'b1;
              nxt_s.pc = s_ff.pc;
              nxt_s.st = ccw_pkg::ST_CALL2;
            end
            ccw_pkg::OP_MEMORY_BYTE_ZERO: begin
              nxt_s.mem_we = 1'b1;
              nxt_s.mem_addr = i_mem_addr;
              nxt_s.mem_wdata = ccw_pkg::ZERO_BYTE;
            end
            ccw_pkg::OP_MEMORY_BIT_ZERO: begin
              nxt_s.mem_we = 1'b1;
              nxt_s.mem_addr = i_mem_addr;
              nxt_s.mem_wdata = i_mem_rdata & ~(8'h01 << i_bit_sel);
            end
            ccw_pkg::OP_WATCHDOG_CLEAR: begin
              nxt_s.wdt_clr = 1'b1;
              nxt_s.status_we = 1'b1;
            end
            ccw_pkg::OP_WATCHDOG_PRECLEAR_FIRST: begin
              if (s_ff.pre == ccw_pkg::PRE_SECOND) begin
                nxt_s.wdt_clr = 1'b1;
                nxt_s.status_we = 1'b1;
                nxt_s.pre = ccw_pkg::PRE_NONE;
              end else begin
                // repeating the same half only re-arms it
                nxt_s.pre = ccw_pkg::PRE_FIRST;
              end
            end
            ccw_pkg::OP_WATCHDOG_PRECLEAR_SECOND: begin
              if (s_ff.pre == ccw_pkg::PRE_FIRST) begin
                nxt_s.wdt_clr = 1'b1;
                nxt_s.status_we = 1'b1;
                nxt_s.pre = ccw_pkg::PRE_NONE;
              end else begin
                nxt_s.pre = ccw_pkg::PRE_SECOND;
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        nxt_s.st = ccw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_pc = s_ff.pc;
  assign o_busy = s_ff.busy;
  assign o_push = s_ff.push;
  assign o_push_data = s_ff.push_data;
  assign o_mem_we = s_ff.mem_we;
  assign o_mem_addr = s_ff.mem_addr;
  assign o_mem_wdata = s_ff.mem_wdata;
  assign o_watchdog_counter_clr = s_ff.wdt_clr;
  assign o_timeout_flag_clr = s_ff.wdt_clr;
  assign o_power_down_flag_clr = s_ff.wdt_clr;
  assign o_status_we = s_ff.status_we;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_call_push;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (take && op == ccw_pkg::OP_CALL) |=> o_push && o_push_data == $past(o_pc) + 10'h001;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong");
  property p_call_load;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (take && op == ccw_pkg::OP_CALL) |=> ##1 o_pc == $past(i_call_addr, 2);
  endproperty
  a_call_load: assert property (p_call_load) else $error("call target not loaded");
  property p_call_two;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (take && op == ccw_pkg::OP_CALL) |=> o_busy ##1 !o_busy;
  endproperty
  a_call_two: assert property (p_call_two) else $error("call not two cycles");
  property p_byte_zero;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (take && op == ccw_pkg::OP_MEMORY_BYTE_ZERO) |=> o_mem_we && o_mem_wdata == 8'h00;
  endproperty
  a_byte_zero: assert property (p_byte_zero) else $error("byte not zeroed");
  property p_bit_zero;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (take && op == ccw_pkg::OP_MEMORY_BIT_ZERO) |=> o_mem_we
        && o_mem_wdata[$past(i_bit_sel)] == 1'b0
        && (o_mem_wdata | (8'h01 << $past(i_bit_sel))) == ($past(i_mem_rdata) | (8'h01 << $past(i_bit_sel)));
  endproperty
  a_bit_zero: assert property (p_bit_zero) else $error("bit zero wrong");
  property p_wdt_clear;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (take && op == ccw_pkg::OP_WATCHDOG_CLEAR) |=> o_watchdog_counter_clr
        && o_timeout_flag_clr && o_power_down_flag_clr;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear missing");
  property p_pair;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (take && op == ccw_pkg::OP_WATCHDOG_PRECLEAR_SECOND && s_ff.pre == ccw_pkg::PRE_FIRST)
        |=> o_watchdog_counter_clr;
  endproperty
  a_pair: assert property (p_pair) else $error("alternate pre-clear ignored");
  property p_repeat;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (take && op == ccw_pkg::OP_WATCHDOG_PRECLEAR_FIRST && s_ff.pre != ccw_pkg::PRE_SECOND)
        |=> !o_watchdog_counter_clr && !o_timeout_flag_clr;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeated pre-clear acted");
  property p_status;
    @(posedge i_ref_clk) disable iff (!rst_n)
      o_status_we |-> $past(op) inside {ccw_pkg::OP_WATCHDOG_CLEAR,
        ccw_pkg::OP_WATCHDOG_PRECLEAR_FIRST, ccw_pkg::OP_WATCHDOG_PRECLEAR_SECOND};
  endproperty
  a_status: assert property (p_status) else $error("status touched by other op");
  c_call: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    take && op == ccw_pkg::OP_CALL ##2 !o_busy);
  c_pair: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_ff.pre == ccw_pkg::PRE_SECOND ##1 o_watchdog_counter_clr);
  c_bit: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    take && op == ccw_pkg::OP_MEMORY_BIT_ZERO);
endmodule : ccw_exec
`default_nettype wire

// File: test_call_clear_wdt_instr_exec.sv
// testbench: self-checking bench for the call / clear / watchdog-clear executor
`timescale 1ns/1ps
`default_nettype none
module test_call_clear_wdt_instr_exec;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] op;
    logic [7:0] addr;
    logic [2:0] bsel;
    logic [7:0] rdata;
    logic we;
    logic [7:0] wdata;
    logic clr;
  } ccw_row_t;
  logic i_ref_clk, i_nrst, i_op_valid;
  logic [2:0] i_op, i_bit_sel;
  logic [9:0] i_call_addr;
  logic [7:0] i_mem_addr, i_mem_rdata;
  logic [9:0] o_pc, o_push_data;
  logic o_busy, o_push, o_mem_we, o_status_we;
  logic o_watchdog_counter_clr, o_timeout_flag_clr, o_power_down_flag_clr;
  logic [7:0] o_mem_addr, o_mem_wdata;
  int n_errors = 0;
  int cmp_count = 0;
  ccw_row_t rows [14];
  ccw_exec DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_call_addr(i_call_addr), .i_mem_addr(i_mem_addr), .i_bit_sel(i_bit_sel),
    .i_mem_rdata(i_mem_rdata), .o_pc(o_pc), .o_busy(o_busy), .o_push(o_push),
    .o_push_data(o_push_data), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_watchdog_counter_clr(o_watchdog_counter_clr),
    .o_timeout_flag_clr(o_timeout_flag_clr), .o_power_down_flag_clr(o_power_down_flag_clr),
    .o_status_we(o_status_we));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // inputs always move 2 ns after the rising edge, outputs are settled by then
  task automatic step();
    @(posedge i_ref_clk);
    #2;
  endtask : step
  task automatic chk_clr(input logic exp);
    chk("counter_clr", 10'(o_watchdog_counter_clr), 10'(exp));
    chk("timeout_clr", 10'(o_timeout_flag_clr), 10'(exp));
    chk("power_down_clr", 10'(o_power_down_flag_clr), 10'(exp));
    chk("status_we", 10'(o_status_we), 10'(exp));
  endtask : chk_clr
  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  // the sequence needs well under 100 cycles; 3000 leaves ample margin
  initial begin
    #(3000 * 25);
    n_errors++;
    summarize();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    // op, addr, bit, rdata, write, wdata, flag clear
    rows = '{'{3'h2, 8'h1f, 3'h0, 8'hff, 1'b1, 8'h00, 1'b0}, '{3'h3, 8'h05, 3'h0, 8'hff, 1'b1, 8'hfe, 1'b0},
      '{3'h3, 8'h06, 3'h7, 8'ha5, 1'b1, 8'h25, 1'b0}, '{3'h3, 8'h07, 3'h3, 8'h08, 1'b1, 8'h00, 1'b0},
      '{3'h4, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b1}, '{3'h5, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0},
      '{3'h5, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0}, '{3'h6, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b1},
      '{3'h6, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0}, '{3'h2, 8'h02, 3'h0, 8'h3c, 1'b1, 8'h00, 1'b0},
      '{3'h5, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b1}, '{3'h7, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0},
      '{3'h0, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0}, '{3'h4, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b1}};
    i_nrst = 1'b0;
    i_op_valid = 1'b0;
    i_op = 3'h0;
    i_bit_sel = 3'h0;
    i_call_addr = 10'h000;
    i_mem_addr = 8'h00;
    i_mem_rdata = 8'h00;
    repeat (6) @(posedge i_ref_clk);
    #2;
    i_nrst = 1'b1;
    step();
    step();
    chk("pc_after_reset", o_pc, 10'h000);
    chk_clr(1'b0);
    // back-to-back table of clear operations plus one other op and one no-op, pulses seen one cycle after take
    foreach (rows[k]) begin
      i_op_valid = 1'b1;
      i_op = rows[k].op;
      i_mem_addr = rows[k].addr;
      i_bit_sel = rows[k].bsel;
      i_mem_rdata = rows[k].rdata;
      step();
      chk("mem_we", 10'(o_mem_we), 10'(rows[k].we));
      if (rows[k].we) begin
        chk("mem_wdata", 10'(o_mem_wdata), 10'(rows[k].wdata));
        chk("mem_addr", 10'(o_mem_addr), 10'(rows[k].addr));
      end
      chk("push", 10'(o_push), 10'h000);
      chk_clr(rows[k].clr);
    end
    // call, an op refused while busy, then a second call right after
    i_op = 3'h1;
    i_call_addr = 10'h2a5;
    step();
    i_op = 3'h4;
    chk("busy", 10'(o_busy), 10'h001);
    chk("push", 10'(o_push), 10'h001);
    chk("status_we", 10'(o_status_we), 10'h000);
    step();
    i_op = 3'h1;
    i_call_addr = 10'h013;
    chk("pc", o_pc, 10'h2a5);
    chk("busy", 10'(o_busy), 10'h000);
    chk_clr(1'b0);
    step();
    i_op_valid = 1'b0;
    chk("push_data", o_push_data, 10'h2a6);
    step();
    chk("pc", o_pc, 10'h013);
    // reset in mid-run swallows a pending watchdog clear
    i_op_valid = 1'b1;
    i_op = 3'h4;
    i_nrst = 1'b0;
    step();
    chk("pc_in_reset", o_pc, 10'h000);
    chk_clr(1'b0);
    summarize();
  end
endmodule : test_call_clear_wdt_instr_exec
`default_nettype wire
